// file: src/wws_pkg.sv
// Package for the windowed watchdog supervisor: timing constants and carriers.
// Assumes a 200 MHz system clock.
package wws_pkg;
  localparam int CLK_MHZ = 200;
  // Times in their natural units
  localparam int FAST_WINDOW_MS = 10;
  localparam int SLOW_WINDOW_MS = 100;
  localparam int FAULT_PULSE_MS = 1;
  localparam int RESET_TIMEOUT_MS = 100;
  localparam int MR_MIN_LOW_NS = 1000;
  localparam int MR_GLITCH_NS = 100;
  // Cycle counts
  localparam int FAST_WINDOW_CYC = FAST_WINDOW_MS * 1000 * CLK_MHZ;
  localparam int SLOW_WINDOW_CYC = SLOW_WINDOW_MS * 1000 * CLK_MHZ;
  localparam int FAULT_PULSE_CYC = FAULT_PULSE_MS * 1000 * CLK_MHZ;
  localparam int RESET_TIMEOUT_CYC = RESET_TIMEOUT_MS * 1000 * CLK_MHZ;
  // Filter sits between glitch width and minimum low width
  localparam int MR_FILTER_CYC = (MR_GLITCH_NS * CLK_MHZ + 999) / 1000 * 4;
  localparam int MR_MIN_CYC = MR_MIN_LOW_NS * CLK_MHZ / 1000;
  localparam int CNT_W = 32;

  typedef struct packed {
    logic kick;
    logic manual_reset_n;
    logic supply_low;
  } wws_in_t;
endpackage

// file: src/wws_supervisor.sv
// Windowed watchdog plus reset generator, single clock domain.
// Assumes kick, manual reset and supply-low arrive asynchronously from pins.
// Notes on behaviour
// - A kick falling edge before the fast window time since the last clear raises a fault pulse.
// - No kick falling edge by the slow window time since the last clear raises a fault pulse.
// - The first kick edge after reset or fault release never raises a fast fault.
// - The timer restarts on each valid kick and whenever reset or fault deasserts.
// - Kicks that land inside the window keep the fault output high.
// - A fault holds the active-low fault output low for the pulse length, then releases it.
// - A fault pulse can only begin while the reset output is high.
// - Manual reset low asserts reset, holds the timer at zero and releases the fault output.
// - Reset asserts while supply is low or manual reset is low.
// - Reset stays asserted for the reset timeout after both causes clear.
// - Kick edges are ignored while reset or the fault output is asserted.
// - Manual reset lows shorter than the glitch filter are rejected; one microsecond lows act.
// - A fault pulse does not assert the reset output by itself.
`timescale 1ns/1ps
module wws_supervisor #(
  parameter int FAST_CYC = wws_pkg::FAST_WINDOW_CYC,
  parameter int SLOW_CYC = wws_pkg::SLOW_WINDOW_CYC,
  parameter int PULSE_CYC = wws_pkg::FAULT_PULSE_CYC,
  parameter int RST_CYC = wws_pkg::RESET_TIMEOUT_CYC,
  parameter int MR_FILT_CYC = wws_pkg::MR_FILTER_CYC
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_wd_kick_in,
  input wire logic i_manual_reset_n,
  input wire logic i_supply_low,
  output logic o_reset_n,
  output logic o_wd_fault_pulse_n,
  output logic o_wd_fault_oe
);
  localparam int W = wws_pkg::CNT_W;

  // A window with fast not below slow could never be met by any kick timing
  initial begin
    window_order_a: assert (FAST_CYC < SLOW_CYC) else $error("fast window not shorter than slow");
  end

  // Terminal count test shared by the filter, reset and pulse counters
  function automatic logic cnt_done(input logic [W-1:0] cnt, input int len);
    cnt_done = cnt >= W'(len - 1);
  endfunction

  wws_pkg::wws_in_t meta_reg;
  wws_pkg::wws_in_t sync_reg;
  logic kick_prev_reg;
  logic mr_filt_reg;
  logic [W-1:0] mr_cnt_reg;
  logic [W-1:0] rst_cnt_reg;
  logic [W-1:0] wd_cnt_reg;
  logic [W-1:0] pulse_cnt_reg;
  logic first_reg;
  logic reset_n_reg;
  logic fault_reg;
  logic reset_n_prev_reg;
  logic fault_prev_reg;

  // Two-stage synchroniser; only the second stage is read
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      meta_reg <= '{kick: 1'b1, manual_reset_n: 1'b1, supply_low: 1'b1};
      sync_reg <= '{kick: 1'b1, manual_reset_n: 1'b1, supply_low: 1'b1};
    end else begin
      meta_reg <= '{kick: i_wd_kick_in, manual_reset_n: i_manual_reset_n, supply_low: i_supply_low};
      sync_reg <= meta_reg;
    end
  end

  // Manual reset debounce: the filtered level follows only after a stable run
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      mr_filt_reg <= 1'b1;
      mr_cnt_reg <= '0;
    end else if (sync_reg.manual_reset_n == mr_filt_reg) begin
      mr_cnt_reg <= '0;
    end else if (cnt_done(mr_cnt_reg, MR_FILT_CYC)) begin
      mr_filt_reg <= sync_reg.manual_reset_n;
      mr_cnt_reg <= '0;
    end else begin
      mr_cnt_reg <= mr_cnt_reg + 1'b1;
    end
  end

  wire logic mr_active = !mr_filt_reg;
  wire logic rst_cause = sync_reg.supply_low || mr_active;

  // Reset generator, independent of the watchdog fault
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      reset_n_reg <= 1'b0;
      rst_cnt_reg <= '0;
    end else if (rst_cause) begin
      reset_n_reg <= 1'b0;
      rst_cnt_reg <= '0;
    end else if (!reset_n_reg) begin
      if (cnt_done(rst_cnt_reg, RST_CYC)) begin
        reset_n_reg <= 1'b1;
      end else begin
        rst_cnt_reg <= rst_cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      kick_prev_reg <= 1'b1;
      reset_n_prev_reg <= 1'b0;
      fault_prev_reg <= 1'b0;
    end else begin
      kick_prev_reg <= sync_reg.kick;
      reset_n_prev_reg <= reset_n_reg;
      fault_prev_reg <= fault_reg;
    end
  end

  wire logic kick_fall = kick_prev_reg && !sync_reg.kick;
  wire logic released = (reset_n_reg && !reset_n_prev_reg) || (!fault_reg && fault_prev_reg);
  wire logic wd_live = reset_n_reg && !fault_reg && !mr_active;
  wire logic fast_hit = wd_live && kick_fall && !first_reg && (wd_cnt_reg < W'(FAST_CYC));
  wire logic slow_hit = wd_live && !kick_fall && (wd_cnt_reg >= W'(SLOW_CYC - 1));
  wire logic fault_start = fast_hit || slow_hit;

  // Watchdog timer and first-kick exemption
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      wd_cnt_reg <= '0;
      first_reg <= 1'b1;
    end else if (!wd_live || released) begin
      wd_cnt_reg <= '0;
      first_reg <= 1'b1;
    end else if (kick_fall) begin
      wd_cnt_reg <= '0;
      first_reg <= 1'b0;
    end else if (!slow_hit) begin
      wd_cnt_reg <= wd_cnt_reg + 1'b1;
    end
  end

  // Fault pulse
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      fault_reg <= 1'b0;
      pulse_cnt_reg <= '0;
    end else if (mr_active) begin
      fault_reg <= 1'b0;
      pulse_cnt_reg <= '0;
    end else if (fault_start) begin
      fault_reg <= 1'b1;
      pulse_cnt_reg <= '0;
    end else if (fault_reg) begin
      if (cnt_done(pulse_cnt_reg, PULSE_CYC)) begin
        fault_reg <= 1'b0;
      end else begin
        pulse_cnt_reg <= pulse_cnt_reg + 1'b1;
      end
    end
  end

  assign o_reset_n = reset_n_reg;
  assign o_wd_fault_pulse_n = !fault_reg;
  // Open drain: drive only while pulling low
  assign o_wd_fault_oe = fault_reg;

  fault_in_reset_a: assert property (@(posedge i_clk) disable iff (i_reset)
    $rose(fault_reg) |-> $past(reset_n_reg)) else $error("fault began during reset");
  fault_no_reset_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (fault_reg && !rst_cause && $past(!rst_cause) && $past(reset_n_reg)) |-> reset_n_reg)
    else $error("fault pulled reset");
  mr_clears_fault_a: assert property (@(posedge i_clk) disable iff (i_reset)
    mr_active |=> !fault_reg && wd_cnt_reg == '0) else $error("manual reset left watchdog active");
  cause_resets_a: assert property (@(posedge i_clk) disable iff (i_reset)
    rst_cause |=> !reset_n_reg) else $error("reset not asserted");
  reset_hold_a: assert property (@(posedge i_clk) disable iff (i_reset)
    $rose(reset_n_reg) |-> rst_cnt_reg == W'(RST_CYC - 1)) else $error("reset released early");
  pulse_len_a: assert property (@(posedge i_clk) disable iff (i_reset)
    $fell(fault_reg) && !$past(mr_active) |-> $past(pulse_cnt_reg) == W'(PULSE_CYC - 1))
    else $error("fault pulse length wrong");
  first_kick_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (wd_live && first_reg && kick_fall) |=> !fault_reg) else $error("first kick made fast fault");
  ignore_kick_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (fault_reg && !mr_active) |=> !$rose(fault_reg) && wd_cnt_reg == '0)
    else $error("kick acted during fault");
  slow_fault_a: assert property (@(posedge i_clk) disable iff (i_reset)
    slow_hit |=> fault_reg) else $error("slow fault missed");
  fast_fault_a: assert property (@(posedge i_clk) disable iff (i_reset)
    fast_hit |=> fault_reg) else $error("fast fault missed");

  // Independent count of quiet cycles while reset is held, for the timeout check
  logic [W-1:0] quiet_cnt_reg;
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      quiet_cnt_reg <= '0;
    end else if (rst_cause || reset_n_reg) begin
      quiet_cnt_reg <= '0;
    end else begin
      quiet_cnt_reg <= quiet_cnt_reg + 1'b1;
    end
  end

  sync_stage_a: assert property (@(posedge i_clk) disable iff (i_reset)
    sync_reg == $past(meta_reg)) else $error("synchroniser stage skipped");

  mr_filt_follow_a: assert property (@(posedge i_clk) disable iff (i_reset)
    $changed(mr_filt_reg) |-> mr_filt_reg == $past(sync_reg.manual_reset_n)) else $error("filter moved wrongly");

  mr_filt_len_a: assert property (@(posedge i_clk) disable iff (i_reset)
    $changed(mr_filt_reg) |-> $past(mr_cnt_reg) == W'(MR_FILT_CYC - 1)) else $error("filter too short");

  mr_cnt_clear_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (sync_reg.manual_reset_n == mr_filt_reg) |=> mr_cnt_reg == '0) else $error("filter count kept");

  mr_cnt_step_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (sync_reg.manual_reset_n != mr_filt_reg && !cnt_done(mr_cnt_reg, MR_FILT_CYC))
    |=> mr_cnt_reg == $past(mr_cnt_reg) + 1'b1 && $stable(mr_filt_reg)) else $error("filter count skipped");

  mr_reset_a: assert property (@(posedge i_clk) disable iff (i_reset)
    mr_active |=> !reset_n_reg && !o_wd_fault_oe) else $error("manual reset not acting");

  supply_reset_a: assert property (@(posedge i_clk) disable iff (i_reset)
    sync_reg.supply_low |=> !reset_n_reg && rst_cnt_reg == '0) else $error("supply low ignored");

  reset_count_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (!rst_cause && !reset_n_reg && !cnt_done(rst_cnt_reg, RST_CYC))
    |=> !reset_n_reg && rst_cnt_reg == $past(rst_cnt_reg) + 1'b1) else $error("reset count skipped");

  reset_release_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (!rst_cause && !reset_n_reg && cnt_done(rst_cnt_reg, RST_CYC)) |=> reset_n_reg) else $error("reset stuck");

  reset_stays_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (reset_n_reg && !rst_cause) |=> reset_n_reg) else $error("reset without cause");

  reset_quiet_a: assert property (@(posedge i_clk) disable iff (i_reset)
    $rose(reset_n_reg) |-> quiet_cnt_reg == W'(RST_CYC)) else $error("reset timeout wrong");

  release_clear_a: assert property (@(posedge i_clk) disable iff (i_reset)
    $rose(reset_n_reg) |=> wd_cnt_reg == '0 && first_reg) else $error("timer not cleared by reset");

  fault_end_clear_a: assert property (@(posedge i_clk) disable iff (i_reset)
    $fell(fault_reg) |=> wd_cnt_reg == '0) else $error("timer not cleared by fault end");

  kick_clear_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (wd_live && kick_fall) |=> wd_cnt_reg == '0) else $error("kick did not clear timer");

  timer_step_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (wd_live && !released && !kick_fall && !slow_hit) |=> wd_cnt_reg == $past(wd_cnt_reg) + 1'b1)
    else $error("timer skipped");

  window_kick_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (wd_live && kick_fall && wd_cnt_reg >= W'(FAST_CYC)) |=> !fault_reg) else $error("good kick faulted");

  no_live_fault_a: assert property (@(posedge i_clk) disable iff (i_reset)
    !wd_live |=> !$rose(fault_reg)) else $error("fault while watchdog idle");

  first_set_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (!wd_live || released) |=> first_reg) else $error("first kick mark lost");

  first_clear_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (wd_live && !released && kick_fall) |=> !first_reg) else $error("first kick mark kept");

  slow_early_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (wd_live && !kick_fall && wd_cnt_reg < W'(SLOW_CYC - 1)) |=> !fault_reg) else $error("slow fault early");

  fault_hold_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (fault_reg && !mr_active && !cnt_done(pulse_cnt_reg, PULSE_CYC)) |=> fault_reg) else $error("pulse cut");

  fault_end_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (fault_reg && !mr_active && cnt_done(pulse_cnt_reg, PULSE_CYC)) |=> !fault_reg) else $error("pulse long");

  pulse_step_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (fault_reg && !mr_active && !cnt_done(pulse_cnt_reg, PULSE_CYC))
    |=> pulse_cnt_reg == $past(pulse_cnt_reg) + 1'b1) else $error("pulse count skipped");

  pulse_start_a: assert property (@(posedge i_clk) disable iff (i_reset)
    fault_start |=> fault_reg && pulse_cnt_reg == '0) else $error("pulse start wrong");

  fault_oe_a: assert property (@(posedge i_clk) disable iff (i_reset)
    o_wd_fault_oe == !o_wd_fault_pulse_n) else $error("fault enable mismatch");

  fault_reset_indep_a: assert property (@(posedge i_clk) disable iff (i_reset)
    fault_start |=> reset_n_reg || $past(rst_cause)) else $error("fault asserted reset");
endmodule

// file: verification/test_wws_supervisor.sv
// Self-checking bench for the windowed watchdog supervisor.
// Assumes short cycle-count parameters; the processor model drives the kick pin.
`timescale 1ns/1ps
module test_wws_supervisor;
  localparam int FAST = 20, SLOW = 100, PULSE = 10, RST = 50;
  logic i_clk = 0, i_reset = 1, i_manual_reset_n = 1, i_supply_low = 0;
  logic i_wd_kick_in, o_reset_n, o_wd_fault_pulse_n, o_wd_fault_oe;
  int bad_count = 0, cmp_count = 0, cyc = 0, seed = 90451, n;
  int exp_q[$];
  always #2.5 i_clk = ~i_clk;
  wws_cpu_model cpu (.i_clk(i_clk), .o_kick(i_wd_kick_in));
  wws_supervisor #(.FAST_CYC(FAST), .SLOW_CYC(SLOW), .PULSE_CYC(PULSE), .RST_CYC(RST), .MR_FILT_CYC(4)) dut (
    .i_clk(i_clk), .i_reset(i_reset), .i_wd_kick_in(i_wd_kick_in), .i_manual_reset_n(i_manual_reset_n),
    .i_supply_low(i_supply_low), .o_reset_n(o_reset_n), .o_wd_fault_pulse_n(o_wd_fault_pulse_n),
    .o_wd_fault_oe(o_wd_fault_oe));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s: got %0h exp %0h", $time, what, got, exp);
    end
  endtask
  task automatic wait_rst();
    n = 0;
    while (o_reset_n !== 1'b1 && n < 400) begin
      @(posedge i_clk);
      n++;
    end
    chk(n >= RST && n < 400, 1, "reset hold");
  endtask
  task automatic wait_q();
    n = 0;
    while (exp_q.size() != 0 && n < 400) begin
      @(posedge i_clk);
      n++;
    end
    chk(exp_q.size(), 0, "fault missing");
  endtask
  task automatic wrap_up();
    $display("compares %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Every fault pulse is measured and matched against the oldest note
  initial begin
    int w;
    forever begin
      @(posedge i_clk);
      if (o_wd_fault_pulse_n === 1'b0) begin
        chk(o_reset_n, 1, "fault during reset");
        chk(o_wd_fault_oe, 1, "fault enable");
        w = 0;
        while (o_wd_fault_pulse_n === 1'b0 && w < 1000) begin
          @(posedge i_clk);
          w++;
        end
        chk(o_reset_n, 1, "fault drove reset");
        if (exp_q.size() == 0) chk(0, 1, "unexpected fault");
        else chk(w, exp_q.pop_front(), "pulse width");
      end
    end
  end
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      wrap_up();
    end
  end
  initial begin
    repeat (4) @(posedge i_clk);
    i_reset <= 1'b0;
    wait_rst();
    $display("test reset_release done");
    cpu.kick(0);
    for (int k = 0; k < 4; k++) cpu.kick(FAST + {$random(seed)} % 60);
    $display("test window_kicks done");
    exp_q.push_back(PULSE);
    cpu.kick(2);
    wait_q();
    $display("test fast_fault done");
    exp_q.push_back(PULSE);
    wait_q();
    $display("test slow_fault done");
    i_manual_reset_n <= 1'b0;
    @(posedge i_clk);
    i_manual_reset_n <= 1'b1;
    repeat (12) @(posedge i_clk);
    chk(o_reset_n, 1, "glitch reset");
    i_manual_reset_n <= 1'b0;
    repeat (12) @(posedge i_clk);
    chk(o_reset_n, 0, "manual reset");
    chk(o_wd_fault_pulse_n, 1, "fault released");
    chk(o_wd_fault_oe, 0, "fault enable idle");
    cpu.kick(0);
    i_manual_reset_n <= 1'b1;
    wait_rst();
    $display("test manual_reset done");
    i_supply_low <= 1'b1;
    repeat (5) @(posedge i_clk);
    chk(o_reset_n, 0, "supply reset");
    i_supply_low <= 1'b0;
    wait_rst();
    $display("test supply_reset done");
    wrap_up();
  end
endmodule

// file: verification/wws_cpu_model.sv
// Model of the supervised processor that drives the kick pin.
// Assumes the bench calls kick() just after a rising clock edge.
`timescale 1ns/1ps
module wws_cpu_model (
  input wire logic i_clk,
  output logic o_kick
);
  initial o_kick = 1'b1;
  // Low phase outlasts the synchroniser so every fall is seen
  task automatic kick(input int gap);
    // At least one edge, so back-to-back calls never drive the pin twice at once
    repeat (gap < 1 ? 1 : gap) @(posedge i_clk);
    o_kick <= 1'b0;
    repeat (4) @(posedge i_clk);
    o_kick <= 1'b1;
  endtask
endmodule
